// file: dpws_host.sv
// Summary of operation
// R1: Array needs select low; flags need flag select.
// R2: Device writes while select and strobe low.
// R3: Write ends at first rising select or strobe.
// R4: Keep strobe high while address changes.
// R5: Select falling after strobe keeps outputs off.
// R6: Never drive data while device drives pins.
// R7: Stretch pulse when output enable is low.
// R8: Hold write data after write ends.
// R9: Wait write-to-read interval before flag read.
// R10: Flag read returns flag on every bit.
// R11: Near-simultaneous claims grant exactly one port.
// R12: Claim by writing zero, then read back.
`timescale 1ns/1ps
`default_nettype none
`include "dpws_map.svh"
module dpws_host (
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  input  wire logic                         cmd_valid,
  output logic                              cmd_ready,
  input  wire dpws_pkg::dpws_op_t           cmd_op,
  input  wire logic [`DPWS_ADDR_W-1:0]      cmd_addr,
  input  wire logic [`DPWS_DATA_W-1:0]      cmd_wdata,
  output logic                              rsp_valid,
  output logic      [`DPWS_DATA_W-1:0]      rsp_data,
  output logic                              rsp_granted,
  output logic                              chip_sel_n,
  output logic                              flag_select_n,
  output logic                              rw_n,
  output logic                              out_en_n,
  output logic      [`DPWS_ADDR_W-1:0]      addr,
  output logic      [`DPWS_DATA_W-1:0]      data_o,
  output logic                              data_oe,
  input  wire logic [`DPWS_DATA_W-1:0]      data_i
);
  // ===================================================================
  // Pin input synchroniser
  // ===================================================================
  logic [`DPWS_DATA_W-1:0] data_sync;

  dpws_sync #(
    .WIDTH (`DPWS_DATA_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (data_i),
    .sync_out (data_sync)
  );

  // ===================================================================
  // Sequencer
  // ===================================================================
  typedef enum logic [2:0] {
    DPWS_IDLE,
    DPWS_SETUP,
    DPWS_PULSE,
    DPWS_HOLD,
    DPWS_GAP,
    DPWS_READ
  } dpws_state_t;

  localparam logic [`DPWS_CNT_W-1:0] SETUP_C = `DPWS_CNT_W'(`DPWS_SETUP_CYC);
  localparam logic [`DPWS_CNT_W-1:0] WPLOW_C =
    `DPWS_CNT_W'(`DPWS_WP_OE_LOW_CYC);
  localparam logic [`DPWS_CNT_W-1:0] WPHI_C =
    `DPWS_CNT_W'(`DPWS_WP_OE_HIGH_CYC);
  localparam logic [`DPWS_CNT_W-1:0] HOLD_C = `DPWS_CNT_W'(`DPWS_HOLD_CYC);
  localparam logic [`DPWS_CNT_W-1:0] SWRD_C = `DPWS_CNT_W'(`DPWS_SWRD_CYC);
  localparam logic [`DPWS_CNT_W-1:0] READ_C = `DPWS_CNT_W'(`DPWS_READ_CYC);

  dpws_state_t               state_reg, state_next;
  logic [`DPWS_CNT_W-1:0]    cnt_reg, cnt_next;
  dpws_pkg::dpws_op_t        op_reg, op_next;
  logic                      is_flag_reg, is_flag_next;
  logic                      claim_reg, claim_next;
  logic [`DPWS_ADDR_W-1:0]   addr_reg, addr_next;
  logic [`DPWS_DATA_W-1:0]   wdata_reg, wdata_next;
  logic                      cs_n_reg, cs_n_next;
  logic                      fs_n_reg, fs_n_next;
  logic                      rw_n_reg, rw_n_next;
  logic                      oe_n_reg, oe_n_next;
  logic                      doe_reg, doe_next;
  logic                      rsp_v_reg, rsp_v_next;
  logic [`DPWS_DATA_W-1:0]   rsp_d_reg, rsp_d_next;
  logic                      grant_reg, grant_next;

  assign cmd_ready = (state_reg == DPWS_IDLE);

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    op_next      = op_reg;
    is_flag_next = is_flag_reg;
    claim_next   = claim_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    cs_n_next    = cs_n_reg;
    fs_n_next    = fs_n_reg;
    rw_n_next    = rw_n_reg;
    oe_n_next    = oe_n_reg;
    doe_next     = doe_reg;
    rsp_v_next   = 1'b0;
    rsp_d_next   = rsp_d_reg;
    grant_next   = grant_reg;
    if (cnt_reg != '0) begin
      cnt_next = cnt_reg - `DPWS_CNT_W'(1);
    end
    case (state_reg)
      DPWS_IDLE: begin
        if (cmd_valid) begin
          // Address moves only here, with strobe and selects high.
          op_next   = cmd_op;
          addr_next = cmd_addr; // see R4
          is_flag_next = (cmd_op == dpws_pkg::DPWS_OP_FLAG_CLAIM) ||
                         (cmd_op == dpws_pkg::DPWS_OP_FLAG_RELEASE);
          claim_next = (cmd_op == dpws_pkg::DPWS_OP_FLAG_CLAIM);
          wdata_next = cmd_wdata;
          if (cmd_op == dpws_pkg::DPWS_OP_FLAG_CLAIM) begin
            wdata_next = '1;
            wdata_next[`DPWS_FLAG_REQ_BIT] = 1'b0; // see R12
          end else if (cmd_op == dpws_pkg::DPWS_OP_FLAG_RELEASE) begin
            wdata_next = '1;
          end
          cnt_next   = SETUP_C;
          state_next = DPWS_SETUP;
        end
      end
      DPWS_SETUP: begin
        if (cnt_reg == '0) begin
          if (op_reg == dpws_pkg::DPWS_OP_ARRAY_READ) begin
            cs_n_next  = 1'b0; // see R1
            oe_n_next  = 1'b0;
            cnt_next   = READ_C;
            state_next = DPWS_READ;
          end else begin
            // Strobe falls with the select so device outputs stay off.
            cs_n_next = is_flag_reg; // see R1
            fs_n_next = ~is_flag_reg; // see R1
            rw_n_next = 1'b0; // see R5
            oe_n_next = 1'b1;
            // Drive data only while device outputs are held off.
            doe_next  = 1'b1; // see R6
            // Output enable is high, so the plain pulse width suffices.
            cnt_next  = oe_n_reg ? WPHI_C : WPLOW_C; // see R7
            state_next = DPWS_PULSE;
          end
        end
      end
      DPWS_PULSE: begin
        if (cnt_reg == '0) begin
          // Strobe and selects rise together, closing the write.
          rw_n_next = 1'b1; // see R3
          cs_n_next = 1'b1;
          fs_n_next = 1'b1;
          cnt_next  = HOLD_C;
          state_next = DPWS_HOLD;
        end
      end
      DPWS_HOLD: begin
        if (cnt_reg == '0) begin
          doe_next = 1'b0; // see R8
          if (claim_reg) begin
            cnt_next   = SWRD_C; // see R9
            state_next = DPWS_GAP;
          end else begin
            rsp_v_next = 1'b1;
            grant_next = 1'b0;
            state_next = DPWS_IDLE;
          end
        end
      end
      DPWS_GAP: begin
        if (cnt_reg == '0) begin
          fs_n_next  = 1'b0; // see R1
          oe_n_next  = 1'b0;
          cnt_next   = READ_C;
          state_next = DPWS_READ;
        end
      end
      DPWS_READ: begin
        if (cnt_reg == '0) begin
          cs_n_next  = 1'b1;
          fs_n_next  = 1'b1;
          oe_n_next  = 1'b1;
          rsp_v_next = 1'b1;
          rsp_d_next = data_sync;
          // The flag appears on bit 0; zero means this port holds it.
          grant_next = claim_reg &&
                       !data_sync[`DPWS_FLAG_REQ_BIT]; // see R10 R11 R12
          state_next = DPWS_IDLE;
        end
      end
      default: begin
        state_next = DPWS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg   <= DPWS_IDLE;
      cnt_reg     <= '0;
      op_reg      <= dpws_pkg::DPWS_OP_ARRAY_WRITE;
      is_flag_reg <= 1'b0;
      claim_reg   <= 1'b0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      cs_n_reg    <= 1'b1;
      fs_n_reg    <= 1'b1;
      rw_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      doe_reg     <= 1'b0;
      rsp_v_reg   <= 1'b0;
      rsp_d_reg   <= '0;
      grant_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      op_reg      <= op_next;
      is_flag_reg <= is_flag_next;
      claim_reg   <= claim_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      cs_n_reg    <= cs_n_next;
      fs_n_reg    <= fs_n_next;
      rw_n_reg    <= rw_n_next;
      oe_n_reg    <= oe_n_next;
      doe_reg     <= doe_next;
      rsp_v_reg   <= rsp_v_next;
      rsp_d_reg   <= rsp_d_next;
      grant_reg   <= grant_next;
    end
  end

  assign chip_sel_n    = cs_n_reg;
  assign flag_select_n = fs_n_reg;
  assign rw_n          = rw_n_reg;
  assign out_en_n      = oe_n_reg;
  assign addr          = addr_reg;
  assign data_o        = wdata_reg;
  assign data_oe       = doe_reg;
  assign rsp_valid     = rsp_v_reg;
  assign rsp_data      = rsp_d_reg;
  assign rsp_granted   = grant_reg;
endmodule
`default_nettype wire

// file: dpws_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpws_map.svh"
// =====================================================================
// Pin-level and command-to-response checks on the host side of the device port.
module dpws_host_checker (
  input wire logic                    sys_clk,
  input wire logic                    reset,
  input wire logic                    cmd_valid,
  input wire logic                    cmd_ready,
  input wire logic                    rsp_valid,
  input wire logic                    chip_sel_n,
  input wire logic                    flag_select_n,
  input wire logic                    rw_n,
  input wire logic                    out_en_n,
  input wire logic [`DPWS_ADDR_W-1:0] addr,
  input wire logic                    data_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_pulse; (!rw_n)[*4]; endsequence
  // Data stays driven for the whole hold count after the strobe rises.
  sequence s_hold; data_oe ##1 data_oe ##1 !data_oe; endsequence
  property p_sel; !(!chip_sel_n && !flag_select_n); endproperty
  a_sel: assert property (p_sel)
    else $error("both selects low");
  property p_wr_sel; $fell(rw_n) |-> chip_sel_n != flag_select_n; endproperty
  a_wr_sel: assert property (p_wr_sel)
    else $error("write strobe without one select");
  property p_end; $rose(rw_n) |-> chip_sel_n && flag_select_n; endproperty
  a_end: assert property (p_end)
    else $error("select still low after strobe rose");
  property p_addr; $changed(addr) |-> rw_n; endproperty
  a_addr: assert property (p_addr)
    else $error("address moved during write");
  property p_quiet; !rw_n |-> out_en_n; endproperty
  a_quiet: assert property (p_quiet)
    else $error("output enable low during write");
  property p_drive; !out_en_n |-> !data_oe; endproperty
  a_drive: assert property (p_drive)
    else $error("bus driven while device may drive");
  property p_pulse; $fell(rw_n) |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse)
    else $error("write pulse too short");
  property p_hold; $rose(rw_n) |-> s_hold; endproperty
  a_hold: assert property (p_hold)
    else $error("write data hold wrong");
  property p_gap; $rose(flag_select_n) |=> flag_select_n; endproperty
  a_gap: assert property (p_gap)
    else $error("flag read too soon after write");
  property p_ans; cmd_valid && cmd_ready |-> ##[2:40] rsp_valid; endproperty
  a_ans: assert property (p_ans)
    else $error("no response to command");
endmodule
bind dpws_host dpws_host_checker u_chk (
  .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .chip_sel_n(chip_sel_n),
  .flag_select_n(flag_select_n), .rw_n(rw_n), .out_en_n(out_en_n),
  .addr(addr), .data_oe(data_oe)
);
`default_nettype wire

// file: dpws_map.svh
`ifndef DPWS_MAP_SVH
`define DPWS_MAP_SVH
// =====================================================================
// Timing figures in ns and derived cycle counts at 100 MHz.
// =====================================================================
`define DPWS_CLK_PERIOD_NS     10
`define DPWS_T_WC_NS           55
`define DPWS_T_WP_NS           40
`define DPWS_T_EW_NS           45
`define DPWS_T_DW_NS           30
`define DPWS_T_WZ_NS           25
`define DPWS_T_OW_NS           0
`define DPWS_T_HZ_NS           25
`define DPWS_T_AA_NS           55
`define DPWS_T_SWRD_NS         5
`define DPWS_T_SU_NS           10
`define DPWS_T_DH_NS           0
`define DPWS_CYC(ns) (((ns) + `DPWS_CLK_PERIOD_NS - 1) / `DPWS_CLK_PERIOD_NS)
`define DPWS_MAX2(a, b) (((a) > (b)) ? (a) : (b))
`define DPWS_WP_OE_LOW_CYC \
  `DPWS_MAX2(`DPWS_CYC(`DPWS_T_WP_NS), \
             `DPWS_CYC(`DPWS_T_WZ_NS + `DPWS_T_OW_NS + `DPWS_T_DW_NS))
`define DPWS_WP_OE_HIGH_CYC \
  `DPWS_MAX2(`DPWS_CYC(`DPWS_T_WP_NS), `DPWS_CYC(`DPWS_T_DW_NS))
`define DPWS_SETUP_CYC \
  `DPWS_MAX2(1, `DPWS_CYC(`DPWS_T_SU_NS))
`define DPWS_HOLD_CYC \
  `DPWS_MAX2(1, `DPWS_CYC(`DPWS_T_DH_NS))
`define DPWS_SWRD_CYC \
  `DPWS_MAX2(1, `DPWS_CYC(`DPWS_T_SWRD_NS))
`define DPWS_READ_CYC \
  `DPWS_MAX2(`DPWS_CYC(`DPWS_T_AA_NS), `DPWS_CYC(`DPWS_T_HZ_NS))
`define DPWS_CNT_W             4
`define DPWS_ADDR_W            16
`define DPWS_DATA_W            8
`define DPWS_FLAG_ADDR_W       3
`define DPWS_FLAG_REQ_BIT      0
`endif

// file: dpws_pkg.sv
package dpws_pkg;
  typedef enum logic [1:0] {
    DPWS_OP_ARRAY_WRITE,
    DPWS_OP_ARRAY_READ,
    DPWS_OP_FLAG_CLAIM,
    DPWS_OP_FLAG_RELEASE
  } dpws_op_t;
endpackage

// file: dpws_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Behavioural device port: byte array plus eight flags.
module dpws_ram_model (
  input  wire logic        sys_clk,
  input  wire logic        chip_sel_n,
  input  wire logic        flag_select_n,
  input  wire logic        rw_n,
  input  wire logic        out_en_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_o,
  input  wire logic [7:0]  other_hold,
  output logic      [7:0]  data_i
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  own = 8'h00;
  logic [7:0]  idle_pat = 8'hA5;
  logic        cap_arr;
  logic [15:0] cap_a;
  logic [7:0]  cap_d;
  wire  logic  wr_act = !rw_n && (chip_sel_n != flag_select_n);
  wire  logic  drv = rw_n && !out_en_n && (chip_sel_n != flag_select_n);
  // Undriven pins toggle so that stale data can never pass for a read.
  always @(posedge sys_clk) idle_pat <= ~idle_pat;
  always @* begin
    if (wr_act) begin
      cap_arr = !chip_sel_n;
      cap_a = addr;
      cap_d = data_o;
    end
  end
  // The write lands when the first of select and strobe rises.
  always @(negedge wr_act) begin
    if (cap_arr) begin
      mem[cap_a] = cap_d;
    end else if (cap_d[0] == 1'b0) begin
      // A flag that the far port holds is refused.
      own[cap_a[2:0]] = own[cap_a[2:0]] | !other_hold[cap_a[2:0]];
    end else begin
      own[cap_a[2:0]] = 1'b0;
    end
  end
  assign data_i = !drv ? idle_pat
                : !chip_sel_n ? mem[addr] : {8{!own[addr[2:0]]}};
endmodule
`default_nettype wire

// file: dpws_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpws_map.svh"
module dpws_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  // First stage feeds only the second to limit metastability spread.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_out = stage2_reg;
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    dpws_pkg::dpws_op_t op;
    logic [15:0]        a;
    logic [7:0]         d;
    logic [7:0]         hold;
    logic [7:0]         exp;
    logic               gr;
    logic               chk;
  } dpws_row_t;
  localparam dpws_pkg::dpws_op_t op_wr = dpws_pkg::DPWS_OP_ARRAY_WRITE;
  localparam dpws_pkg::dpws_op_t op_rd = dpws_pkg::DPWS_OP_ARRAY_READ;
  localparam dpws_pkg::dpws_op_t op_cl = dpws_pkg::DPWS_OP_FLAG_CLAIM;
  localparam dpws_pkg::dpws_op_t op_rl = dpws_pkg::DPWS_OP_FLAG_RELEASE;
  logic               sys_clk = 1'b0;
  logic               reset, cmd_valid, cmd_ready, rsp_valid, rsp_granted;
  logic               chip_sel_n, flag_select_n, rw_n, out_en_n, data_oe;
  dpws_pkg::dpws_op_t cmd_op;
  logic [15:0]        cmd_addr, addr;
  logic [7:0]         cmd_wdata, rsp_data, data_o, data_i, other_hold;
  int                 bad_count = 0;
  int                 checks_done = 0;
  dpws_row_t          rows [9] = '{
    '{op_wr, 16'h0000, 8'h5A, 8'h00, 8'h00, 1'b0, 1'b0},
    '{op_wr, 16'hFFFF, 8'hA5, 8'h00, 8'h00, 1'b0, 1'b0},
    '{op_rd, 16'h0000, 8'h00, 8'h00, 8'h5A, 1'b0, 1'b1},
    '{op_rd, 16'hFFFF, 8'h00, 8'h00, 8'hA5, 1'b0, 1'b1},
    '{op_cl, 16'h0003, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1},
    '{op_rl, 16'h0003, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0},
    '{op_cl, 16'h0005, 8'h00, 8'h20, 8'hFF, 1'b0, 1'b1},
    '{op_cl, 16'hFFFB, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1},
    '{op_rd, 16'h0000, 8'h00, 8'h00, 8'h5A, 1'b0, 1'b1}};
  dpws_host u_dut (
    .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_granted(rsp_granted), .chip_sel_n(chip_sel_n),
    .flag_select_n(flag_select_n), .rw_n(rw_n), .out_en_n(out_en_n),
    .addr(addr), .data_o(data_o), .data_oe(data_oe), .data_i(data_i));
  dpws_ram_model u_ram (
    .sys_clk(sys_clk), .chip_sel_n(chip_sel_n), .flag_select_n(flag_select_n),
    .rw_n(rw_n), .out_en_n(out_en_n), .addr(addr), .data_o(data_o),
    .other_hold(other_hold), .data_i(data_i));
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Called at a falling edge; returns at the falling edge of the answer.
  task automatic do_cmd(input dpws_pkg::dpws_op_t op, input logic [15:0] a,
                        input logic [7:0] d);
    int n;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    check("response", 16'(rsp_valid), 16'h0001);
  endtask
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = op_wr;
    cmd_addr = 16'h0000;
    cmd_wdata = 8'h00;
    other_hold = 8'h00;
    repeat (20) @(negedge sys_clk);
    check("idle pins", 16'({chip_sel_n, flag_select_n, rw_n, out_en_n,
          data_oe, cmd_ready}), 16'h003D);
    reset = 1'b0;
    $display("test reset done");
    // Rows run back to back: each command starts at its predecessor's answer.
    foreach (rows[i]) begin
      other_hold = rows[i].hold;
      do_cmd(rows[i].op, rows[i].a, rows[i].d);
      check("rsp_granted", 16'(rsp_granted), 16'(rows[i].gr));
      if (rows[i].chk) begin
        check("rsp_data", 16'(rsp_data), 16'(rows[i].exp));
      end
    end
    $display("test table done");
    cmd_op = op_wr;
    cmd_addr = 16'h0010;
    cmd_wdata = 8'h33;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
    reset = 1'b1;
    #1;
    check("abort pins", 16'({chip_sel_n, flag_select_n, rw_n, out_en_n,
          data_oe, cmd_ready}), 16'h003D);
    @(negedge sys_clk);
    reset = 1'b0;
    do_cmd(op_rd, 16'h0000, 8'h00);
    check("rsp_data", 16'(rsp_data), 16'h005A);
    $display("test abort done");
    summarize();
  end
endmodule
`default_nettype wire
